// ===== core/cp_control_regs.sv
// Module: configuration and command registers of the content-protection transmitter
//
// Function
// - Repeater bit adds repeater authentication steps
// - Two-bit mode selects encryption decision
// - Mode resets to 11 with strap, else 00
// - Wait bit inserts 100 ms after start
// - Select bit also requires receiver lock
// - Mute bit written with enhanced bit ignores encryption controls
// - Reset command resets, disables authentication, clears
// - Key list approval completes authentication, self-clears
// - Key approval cleared by key-ready flag
// - Encrypt disable sends plain video, self-clears
// - Encrypt enable: cipher if authenticated, else blue
// - Always-encrypt mode reads enable as 1
// - Authentication disable command, self-clearing
// - Enable starts or restarts, reads status
// - Enhanced bit picks enhanced or original signaling
// - Non-repeater pauses until key approved
// - Authenticated flag cleared on loss or restart
`default_nettype none
module cp_control_regs
  import cp_regs_pkg::*;
#(
  parameter int WAIT_CYC = cp_regs_pkg::WAIT_CYCLES
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic repeater_strap,
  input wire logic receiver_key_ready,
  input wire logic auth_success,
  input wire logic auth_lost,
  input wire logic inband_encrypt,
  input wire logic receiver_detected,
  input wire logic receiver_locked,
  output logic repeater_mode_enable,
  output logic [1:0] encrypt_mode,
  output logic enhanced_status_signaling,
  output logic enhanced_link_verify,
  output logic output_mute_enable,
  output logic receiver_detect_event,
  output logic protection_reset,
  output logic auth_disable_cmd,
  output logic auth_start,
  output logic key_list_approved,
  output logic receiver_key_approved,
  output logic encrypt_disable_cmd,
  output logic auth_pause,
  output logic authenticated_flag,
  output logic encrypt_on,
  output logic blue_screen
);
  import cp_regs_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_always(input logic [1:0] mode);
    is_always = (mode == MODE_ENC_ALWAYS);
  endfunction : is_always

  logic wr_cfg, wr_ctl;
  assign wr_cfg = reg_wr && (reg_addr == ADDR_CONFIG);
  assign wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);

  logic cmd_rst, cmd_dis, cmd_en;
  assign cmd_rst = wr_ctl && reg_wdata[CTL_RESET_BIT];
  assign cmd_dis = wr_ctl && reg_wdata[CTL_AUTH_DIS_BIT];
  assign cmd_en = wr_ctl && reg_wdata[CTL_AUTH_EN_BIT];

  // ----------------------------------------
  // Config register
  // ----------------------------------------
  logic enh_lv_r, enhanced_r, repeater_r, wait_en_r, qualify_r, mute_r, strap_done_r;
  logic [1:0] mode_r;

  // Mode default follows the strap, caught on the first edge after release
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enh_lv_r <= CONFIG_RESET[CFG_ENH_LINK_BIT];
      enhanced_r <= CONFIG_RESET[CFG_ENHANCED_BIT];
      repeater_r <= CONFIG_RESET[CFG_REPEATER_BIT];
      mode_r <= CONFIG_RESET[CFG_MODE_HI:CFG_MODE_LO];
      wait_en_r <= CONFIG_RESET[CFG_WAIT_BIT];
      qualify_r <= CONFIG_RESET[CFG_QUALIFY_BIT];
      mute_r <= CONFIG_RESET[CFG_MUTE_BIT];
      strap_done_r <= 1'b0;
    end
    else
    begin
      strap_done_r <= 1'b1;
      if (!strap_done_r)
        mode_r <= repeater_strap ? MODE_ENC_INBAND : MODE_ENC_AUTHENTICATED_FLAG;
      else if (wr_cfg)
        mode_r <= reg_wdata[CFG_MODE_HI:CFG_MODE_LO];
      if (wr_cfg)
      begin
        enh_lv_r <= reg_wdata[CFG_ENH_LINK_BIT];
        enhanced_r <= reg_wdata[CFG_ENHANCED_BIT];
        repeater_r <= reg_wdata[CFG_REPEATER_BIT];
        wait_en_r <= reg_wdata[CFG_WAIT_BIT];
        qualify_r <= reg_wdata[CFG_QUALIFY_BIT];
        // Mute only sticks alongside enhanced signaling
        mute_r <= reg_wdata[CFG_MUTE_BIT] & reg_wdata[CFG_ENHANCED_BIT];
      end
    end
  end

  // ----------------------------------------
  // Command pulses and control state
  // ----------------------------------------
  logic rst_p_r, dis_p_r, list_p_r, encdis_p_r, auth_en_r, enc_en_r, key_ok_r, kr_d_r;
  logic timer_busy, timer_done, start_p_r;

  // Commands are one-cycle pulses and never stored as read data
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_p_r <= 1'b0;
      dis_p_r <= 1'b0;
      list_p_r <= 1'b0;
      encdis_p_r <= 1'b0;
    end
    else
    begin
      rst_p_r <= cmd_rst;
      dis_p_r <= cmd_dis | cmd_rst;
      list_p_r <= wr_ctl && reg_wdata[CTL_LIST_OK_BIT];
      encdis_p_r <= wr_ctl && reg_wdata[CTL_ENC_DIS_BIT];
    end
  end

  // Enabled status; disable and reset beat a simultaneous enable
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      auth_en_r <= CONTROL_RESET[CTL_AUTH_EN_BIT];
    else if (cmd_rst || cmd_dis)
      auth_en_r <= 1'b0;
    else if (cmd_en)
      auth_en_r <= 1'b1;
  end

  // Encrypt enable; a disable command drops it but keeps authentication
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      enc_en_r <= CONTROL_RESET[CTL_ENC_EN_BIT];
    else if (wr_ctl && reg_wdata[CTL_ENC_DIS_BIT])
      enc_en_r <= 1'b0;
    else if (wr_ctl)
      enc_en_r <= reg_wdata[CTL_ENC_EN_BIT];
  end

  // Key approval: host set wins over a same-cycle ready edge
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_ok_r <= 1'b0;
      kr_d_r <= 1'b0;
    end
    else
    begin
      kr_d_r <= receiver_key_ready;
      if (wr_ctl && reg_wdata[CTL_KEY_OK_BIT])
        key_ok_r <= 1'b1;
      else if (receiver_key_ready && !kr_d_r)
        key_ok_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Start with optional wait
  // ----------------------------------------
  cp_wait_timer #(.CYCLES(WAIT_CYC), .CNT_W(WAIT_CNT_W)) u_wait (
    .clock(clock),
    .arst_n(arst_n),
    .start(cmd_en && !cmd_rst && !cmd_dis && wait_en_r),
    .cancel(cmd_rst || cmd_dis),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Engine start arrives directly or after the wait elapses
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      start_p_r <= 1'b0;
    else
      start_p_r <= (cmd_en && !cmd_rst && !cmd_dis && !wait_en_r) || timer_done;
  end

  // ----------------------------------------
  // Status and video controls
  // ----------------------------------------
  logic authenticated_flag_r, pause_r, det_r, enc_on_r, blue_r;

  // Success wins over nothing; loss, restart, disable and reset clear
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      authenticated_flag_r <= 1'b0;
    else if (auth_lost || cmd_en || cmd_dis || cmd_rst)
      authenticated_flag_r <= 1'b0;
    else if (auth_success && auth_en_r)
      authenticated_flag_r <= 1'b1;
  end

  // Pause and receiver detect qualification
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pause_r <= 1'b0;
      det_r <= 1'b0;
    end
    else
    begin
      pause_r <= !repeater_r && receiver_key_ready && !key_ok_r;
      det_r <= receiver_detected && (!qualify_r || receiver_locked);
    end
  end

  // Encryption decision, frozen while muted
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enc_on_r <= 1'b0;
      blue_r <= 1'b0;
    end
    else if (!mute_r)
    begin
      case (mode_r)
        MODE_ENC_AUTHENTICATED_FLAG: enc_on_r <= authenticated_flag_r;
        MODE_ENC_REG: enc_on_r <= enc_en_r && authenticated_flag_r;
        MODE_ENC_ALWAYS: enc_on_r <= authenticated_flag_r;
        MODE_ENC_INBAND: enc_on_r <= inband_encrypt && authenticated_flag_r;
        default: enc_on_r <= 1'b0;
      endcase
      blue_r <= (enc_en_r || is_always(mode_r)) && !authenticated_flag_r;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rdata_r;

  // Commands and reserved bit read zero
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= '0;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_CONFIG)
        rdata_r <= {enh_lv_r, enhanced_r, repeater_r, mode_r, wait_en_r, qualify_r, mute_r};
      else if (reg_addr == ADDR_CONTROL)
        rdata_r <= {2'b00, 1'b0, key_ok_r, 1'b0,
                    enc_en_r | is_always(mode_r), 1'b0, auth_en_r};
      else
        rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
  assign repeater_mode_enable = repeater_r;
  assign encrypt_mode = mode_r;
  assign enhanced_status_signaling = enhanced_r;
  assign enhanced_link_verify = enh_lv_r;
  assign output_mute_enable = mute_r;
  assign receiver_detect_event = det_r;
  assign protection_reset = rst_p_r;
  assign auth_disable_cmd = dis_p_r;
  assign auth_start = start_p_r;
  assign key_list_approved = list_p_r;
  assign receiver_key_approved = key_ok_r;
  assign encrypt_disable_cmd = encdis_p_r;
  assign auth_pause = pause_r;
  assign authenticated_flag = authenticated_flag_r;
  assign encrypt_on = enc_on_r;
  assign blue_screen = blue_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_RST_PULSE: assert property (@(posedge clock) disable iff (!arst_n)
    cmd_rst |=> protection_reset && auth_disable_cmd ##1 (protection_reset == $past(cmd_rst)))
    else $error("reset command pulse wrong");
  AST_WAIT_ENABLED: assert property (@(posedge clock) disable iff (!arst_n)
    timer_busy |-> auth_en_r)
    else $error("wait timer running while not enabled");
  AST_DIS_CLEARS: assert property (@(posedge clock) disable iff (!arst_n)
    cmd_dis |=> !auth_en_r && auth_disable_cmd)
    else $error("disable did not clear enable");
  AST_NOWAIT_START: assert property (@(posedge clock) disable iff (!arst_n)
    (cmd_en && !cmd_rst && !cmd_dis && !wait_en_r) |=> auth_start && auth_en_r)
    else $error("start pulse missing");
  AST_WAIT_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    (cmd_en && !cmd_rst && !cmd_dis && wait_en_r) |=> !auth_start [*3])
    else $error("start came before wait");
  AST_ALWAYS_READ: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && reg_addr == ADDR_CONTROL && is_always(mode_r)) |=> reg_rdata[CTL_ENC_EN_BIT])
    else $error("enable bit not one in always mode");
  AST_CMD_READ0: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && reg_addr == ADDR_CONTROL) |=> (reg_rdata & 8'h00EA) == 8'h0000)
    else $error("command or reserved bit read nonzero");
  AST_RESTART_UNAUTH: assert property (@(posedge clock) disable iff (!arst_n)
    (cmd_en || auth_lost) |=> !authenticated_flag)
    else $error("authenticated survived restart");
  AST_KEY_CLEAR: assert property (@(posedge clock) disable iff (!arst_n)
    (receiver_key_ready && !kr_d_r && !(wr_ctl && reg_wdata[CTL_KEY_OK_BIT]))
      |=> !receiver_key_approved)
    else $error("key approval not cleared");
  AST_PAUSE: assert property (@(posedge clock) disable iff (!arst_n)
    (!repeater_r && receiver_key_ready && !key_ok_r) |=> auth_pause)
    else $error("no pause awaiting approval");
  AST_DETECT: assert property (@(posedge clock) disable iff (!arst_n)
    (qualify_r && !receiver_locked) |=> !receiver_detect_event)
    else $error("detect without lock");
  AST_MUTE_FREEZE: assert property (@(posedge clock) disable iff (!arst_n)
    mute_r |=> $stable(encrypt_on))
    else $error("encryption changed under mute");
endmodule : cp_control_regs
`default_nettype wire

// ===== pkg/cp_regs_pkg.sv
// Package: offsets, field positions, reset values and timing for the protection registers
`default_nettype none
package cp_regs_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00_C2;
  localparam logic [7:0] ADDR_CONTROL = 8'h00_C3;

  // ----------------------------------------
  // Config register fields
  // ----------------------------------------
  localparam int CFG_ENH_LINK_BIT = 7;
  localparam int CFG_ENHANCED_BIT = 6;
  localparam int CFG_REPEATER_BIT = 5;
  localparam int CFG_MODE_HI = 4;
  localparam int CFG_MODE_LO = 3;
  localparam int CFG_WAIT_BIT = 2;
  localparam int CFG_QUALIFY_BIT = 1;
  localparam int CFG_MUTE_BIT = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h0080;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_RESET_BIT = 7;
  localparam int CTL_LIST_OK_BIT = 5;
  localparam int CTL_KEY_OK_BIT = 4;
  localparam int CTL_ENC_DIS_BIT = 3;
  localparam int CTL_ENC_EN_BIT = 2;
  localparam int CTL_AUTH_DIS_BIT = 1;
  localparam int CTL_AUTH_EN_BIT = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h0000;

  // ----------------------------------------
  // Encryption control modes
  // ----------------------------------------
  localparam logic [1:0] MODE_ENC_AUTHENTICATED_FLAG = 2'h0;
  localparam logic [1:0] MODE_ENC_REG = 2'h1;
  localparam logic [1:0] MODE_ENC_ALWAYS = 2'h2;
  localparam logic [1:0] MODE_ENC_INBAND = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_KHZ = 40000;
  localparam int WAIT_MS = 100;
  localparam int WAIT_CYCLES = WAIT_MS * CLOCK_KHZ;
  localparam int WAIT_CNT_W = 23;
endpackage : cp_regs_pkg
`default_nettype wire

// ===== core/cp_wait_timer.sv
// Module: post-start wait timer that lets the receiver prepare its cipher values
`default_nettype none
module cp_wait_timer
#(
  parameter int CYCLES = cp_regs_pkg::WAIT_CYCLES,
  parameter int CNT_W = cp_regs_pkg::WAIT_CNT_W
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire logic cancel,
  output logic busy,
  output logic done
);
  import cp_regs_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  // Count while busy; cancel always wins so a reset never leaks a late start
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (cancel)
      begin
        busy_r <= 1'b0;
        cnt_r <= '0;
      end
      else if (start)
      begin
        busy_r <= 1'b1;
        cnt_r <= '0;
      end
      else if (busy_r)
      begin
        if (cnt_r == CNT_W'(CYCLES - 1))
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule : cp_wait_timer
`default_nettype wire

// ===== test/cp_host_model.sv
// Host model: control-bus master that programs the protection registers
`default_nettype none
module cp_host_model
(
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus; released lines show the inverse so stale values never match
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write strobe, fields held until the taking edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : write

  // Read data is sampled one cycle after the taking edge, where it has settled
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask : read
endmodule : cp_host_model
`default_nettype wire

// ===== test/content_protection_control_regs_tb_top.sv
// Testbench top for the protection configuration and command registers
`default_nettype none
module content_protection_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cp_regs_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int WC = 10;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic repeater_strap = 1'b0, receiver_key_ready = 1'b0, auth_success = 1'b0;
  logic auth_lost = 1'b0, inband_encrypt = 1'b0;
  logic receiver_detected = 1'b0, receiver_locked = 1'b0;
  logic repeater_mode_enable, enhanced_status_signaling, enhanced_link_verify;
  logic output_mute_enable, receiver_detect_event, protection_reset, auth_disable_cmd;
  logic auth_start, key_list_approved, receiver_key_approved, encrypt_disable_cmd;
  logic auth_pause, authenticated_flag, encrypt_on, blue_screen;
  logic [1:0] encrypt_mode;
  int num_errors = 0;
  int samples_checked = 0;
  int pc [5];

  always #12.5 clock = ~clock;

  cp_host_model u_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  cp_control_regs #(.WAIT_CYC(WC)) u_dut (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .repeater_strap(repeater_strap), .receiver_key_ready(receiver_key_ready),
    .auth_success(auth_success), .auth_lost(auth_lost), .inband_encrypt(inband_encrypt),
    .receiver_detected(receiver_detected), .receiver_locked(receiver_locked),
    .repeater_mode_enable(repeater_mode_enable), .encrypt_mode(encrypt_mode),
    .enhanced_status_signaling(enhanced_status_signaling),
    .enhanced_link_verify(enhanced_link_verify), .output_mute_enable(output_mute_enable),
    .receiver_detect_event(receiver_detect_event), .protection_reset(protection_reset),
    .auth_disable_cmd(auth_disable_cmd), .auth_start(auth_start),
    .key_list_approved(key_list_approved), .receiver_key_approved(receiver_key_approved),
    .encrypt_disable_cmd(encrypt_disable_cmd), .auth_pause(auth_pause),
    .authenticated_flag(authenticated_flag), .encrypt_on(encrypt_on),
    .blue_screen(blue_screen));

  // Pulse counters, same bit order as command bits {3,5,0,1,7}
  always @(posedge clock)
  begin
    pc[4] += (encrypt_disable_cmd === 1'b1);
    pc[3] += (key_list_approved === 1'b1);
    pc[2] += (auth_start === 1'b1);
    pc[1] += (auth_disable_cmd === 1'b1);
    pc[0] += (protection_reset === 1'b1);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic do_reset(input logic s);
    @(posedge clock);
    arst_n <= 1'b0;
    repeater_strap <= s;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    step(2);
  endtask : do_reset

  task automatic test_done;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    do_reset(1'b1);
    u_host.read(ADDR_CONFIG, d);
    check("cfg_strap", d, 8'h98);
    do_reset(1'b0);
    u_host.read(ADDR_CONFIG, d);
    check("cfg_plain", d, 8'h80);
    u_host.read(ADDR_CONTROL, d);
    check("ctl_reset", d, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_config;
    logic [7:0] d, w;
    for (int m = 0; m < 4; m++)
    begin
      w = {1'b1, 1'b0, m[0], m[1:0], m[1], m[0], 1'b0};
      u_host.write(ADDR_CONFIG, w);
      step(2);
      check("mode", {6'h00, encrypt_mode}, 8'(m));
      check("repeater", {7'h00, repeater_mode_enable}, {7'h00, m[0]});
      u_host.read(ADDR_CONFIG, d);
      check("cfg_rd", d, w);
      u_host.read(ADDR_CONTROL, d);
      check("enc_ro", d, (m == 2) ? 8'h04 : 8'h00);
    end
    // Mute requested together with enhanced signaling
    u_host.write(ADDR_CONFIG, 8'h41);
    step(2);
    check("mute_on", {enhanced_link_verify, output_mute_enable, enhanced_status_signaling},
      8'h03);
    u_host.write(ADDR_CONFIG, 8'h01);
    step(2);
    check("mute_refused", {7'h00, output_mute_enable}, 8'h00);
    u_host.write(ADDR_CONFIG, 8'h80);
    $display("t_config done");
  endtask : t_config

  task automatic t_cmds;
    logic [47:0] seq;
    logic [7:0] c, d;
    logic [4:0] got;
    seq = 48'h0820_0201_8001;
    for (int i = 0; i < 6; i++)
    begin
      c = seq[8*i +: 8];
      pc = '{default: 0};
      u_host.write(ADDR_CONTROL, c);
      step(3);
      for (int j = 0; j < 5; j++)
        got[j] = (pc[j] == 0) ? 1'b0 : (pc[j] == 1) ? 1'b1 : 1'bx;
      check("pulses", {3'h0, got}, {3'h0, c[3], c[5], c[0], c[1] | c[7], c[7]});
      u_host.read(ADDR_CONTROL, d);
      check("ctl_rd", d, {7'h00, i == 0 || i == 2});
    end
    u_host.write(ADDR_CONTROL, 8'h40);
    u_host.read(ADDR_CONTROL, d);
    check("reserved", d, 8'h00);
    $display("t_cmds done");
  endtask : t_cmds

  task automatic t_wait;
    int n;
    n = 0;
    u_host.write(ADDR_CONFIG, 8'h84);
    pc = '{default: 0};
    u_host.write(ADDR_CONTROL, 8'h01);
    while (pc[2] == 0 && n < 100)
    begin
      step(1);
      n++;
    end
    check("wait_span", 8'(n >= WC && n <= WC + 4), 8'h01);
    u_host.write(ADDR_CONFIG, 8'h80);
    $display("t_wait done");
  endtask : t_wait

  task automatic pulse_auth(input logic ok);
    @(posedge clock);
    if (ok)
      auth_success <= 1'b1;
    else
      auth_lost <= 1'b1;
    @(posedge clock);
    auth_success <= 1'b0;
    auth_lost <= 1'b0;
    step(2);
  endtask : pulse_auth

  task automatic t_auth;
    u_host.write(ADDR_CONFIG, 8'h88);
    u_host.write(ADDR_CONTROL, 8'h01);
    pulse_auth(1'b1);
    // Host keeps encryption on for protected video
    u_host.write(ADDR_CONTROL, 8'h04);
    step(2);
    check("enc_authenticated_flag", {authenticated_flag, encrypt_on, blue_screen}, 8'h06);
    pulse_auth(1'b0);
    check("enc_lost", {authenticated_flag, blue_screen}, 8'h01);
    pulse_auth(1'b1);
    u_host.write(ADDR_CONTROL, 8'h08);
    step(2);
    check("enc_dis", {authenticated_flag, encrypt_on}, 8'h02);
    u_host.write(ADDR_CONTROL, 8'h05);
    step(2);
    check("restart", {7'h00, authenticated_flag}, 8'h00);
    // Mute freezes the blue screen against a later encrypt disable
    u_host.write(ADDR_CONFIG, 8'hC9);
    u_host.write(ADDR_CONTROL, 8'h08);
    step(2);
    check("mute_freeze", {7'h00, blue_screen}, 8'h01);
    u_host.write(ADDR_CONFIG, 8'h80);
    $display("t_auth done");
  endtask : t_auth

  // Every encryption mode, before authentication with in-band request off, then after it with in-band request off and on
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clock) inband_encrypt <= 1'b0;
      u_host.write(ADDR_CONFIG, 8'h80 | 8'(m << 3));
      u_host.write(ADDR_CONTROL, 8'h01);
      step(2);
      check("blue_always", {7'h00, blue_screen}, 8'(m == 2));
      pulse_auth(1'b1);
      check("enc_mode", {7'h00, encrypt_on}, 8'(m == 0 || m == 2));
      @(posedge clock) inband_encrypt <= 1'b1;
      step(2);
      check("enc_inband", {7'h00, encrypt_on}, 8'(m != 1));
    end
    @(posedge clock) inband_encrypt <= 1'b0;
    u_host.write(ADDR_CONFIG, 8'h80);
    $display("t_modes done");
  endtask : t_modes

  task automatic t_key;
    u_host.write(ADDR_CONTROL, 8'h01);
    @(posedge clock) receiver_key_ready <= 1'b1;
    step(2);
    check("pause", {7'h00, auth_pause}, 8'h01);
    u_host.write(ADDR_CONTROL, 8'h10);
    step(2);
    check("approved", {receiver_key_approved, auth_pause}, 8'h02);
    @(posedge clock) receiver_key_ready <= 1'b0;
    u_host.write(ADDR_CONTROL, 8'h00);
    step(2);
    check("zero_write", {7'h00, receiver_key_approved}, 8'h01);
    @(posedge clock) receiver_key_ready <= 1'b1;
    step(3);
    check("key_clear", {7'h00, receiver_key_approved}, 8'h00);
    $display("t_key done");
  endtask : t_key

  task automatic t_detect;
    for (int q = 0; q < 2; q++)
    begin
      u_host.write(ADDR_CONFIG, 8'h80 | 8'(q << 1));
      @(posedge clock) receiver_detected <= 1'b1;
      step(3);
      check("detect", {7'h00, receiver_detect_event}, 8'(q == 0));
      @(posedge clock) receiver_locked <= 1'b1;
      step(3);
      check("locked", {7'h00, receiver_detect_event}, 8'h01);
      @(posedge clock) receiver_detected <= 1'b0;
      receiver_locked <= 1'b0;
    end
    $display("t_detect done");
  endtask : t_detect

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    t_reset();
    t_config();
    t_cmds();
    t_wait();
    t_auth();
    t_modes();
    t_key();
    t_detect();
    test_done();
  end

  // Generous bound: the whole sequence needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    num_errors++;
    test_done();
  end
endmodule : content_protection_control_regs_tb_top
`default_nettype wire
